// ===== rtl/usp_pkg.sv
package usp_pkg;
  // strap capture: last settle count; the straps are caught on the fifth clock edge after reset release
  localparam logic [3:0] STRAP_SETTLE_CYC = 4'h3;
  // reset values of the captured straps (high = plain uart / flow-control rts)
  localparam logic       STRAP_RESET_VAL  = 1'b1;
  // pin idle levels
  localparam logic       TX_IDLE_UART     = 1'b1;
  localparam logic       TX_IDLE_IR       = 1'b0;
  localparam logic       RX_IDLE_UART     = 1'b1;

  // captured strap configuration
  typedef struct packed {
    logic half_duplex_n;  // low = automatic half-duplex direction on rts
    logic infrared_n;     // low = infrared encoding on tx/rx
    logic valid;          // straps have been caught
  } usp_straps_t;

  // strap capture states
  typedef enum logic [1:0] {
    USP_ST_SETTLE = 2'b00,
    USP_ST_CAPTURE = 2'b01,
    USP_ST_LOCKED = 2'b10
  } usp_state_t;
endpackage

// ===== rtl/usp_sync2.sv
// two-flop synchroniser for one level
module usp_sync2 (
  // clock and reset
  input  wire logic clk_sys_in,
  input  wire logic rst_n_in,
  // level
  input  wire logic d_in,
  output logic      q_out
);
  logic meta;  // first stage, read only by the second

  // reset value is constant; pins other than the sleep pin are idle-high so pick 1
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta  <= 1'b1;
      q_out <= 1'b1;
    end else begin
      meta  <= d_in;
      q_out <= meta;
    end
  end
endmodule

// ===== rtl/usp_pin_control.sv
// Contract
// R1 - sample half-duplex strap once at power-up
// R2 - strap high: rts is flow control/gpo
// R3 - strap low: rts is half-duplex direction
// R4 - sample infrared strap once at power-up
// R5 - ir strap high: plain serial tx/rx
// R6 - ir strap low: infrared tx and rx
// R7 - sleep pin powers up as input
// R8 - sleep input forces sleep after next byte
// R9 - sleep pin as output reports sleep
// R10 - tx idles 1 plain, 0 infrared
// R11 - captured straps ignore later pin changes
module usp_pin_control (
  // clock and reset
  input  wire logic clk_sys_in,
  input  wire logic rst_n_in,
  // strap pins
  input  wire logic half_duplex_strap_n_in,
  input  wire logic infrared_strap_n_in,
  // uart core side
  input  wire logic rts_flow_n_in,      // flow-control / gpo rts level
  input  wire logic tx_dir_in,          // 1 while transmitter drives the line
  input  wire logic tx_data_in,         // plain serial data, 1 = idle
  input  wire logic tx_ir_in,           // ir-encoded data, 0 = idle
  input  wire logic tx_active_in,       // transmitter has data in flight
  input  wire logic byte_done_in,       // one-cycle pulse: byte sent or received
  input  wire logic sleep_cond_in,      // normal sleep conditions met
  input  wire logic wake_in,            // wake event clears sleep
  input  wire logic sleep_pin_out_en_in,// software chose sleep pin as output
  // serial pins
  output logic      rts_n_out,
  output logic      tx_out,
  input  wire logic rx_pin_in,
  output logic      rx_plain_out,       // rx data for plain decoder
  output logic      rx_ir_out,          // rx data for ir decoder
  // sleep / power-down pin
  input  wire logic sleep_powerdown_pin_in,
  output logic      sleep_powerdown_pin_out,
  output logic      sleep_powerdown_pin_oe_n_out,
  // status
  output logic      sleep_out,
  output logic      ir_mode_out,
  output logic      half_duplex_mode_out
);
  usp_pkg::usp_straps_t straps;         // captured straps
  usp_pkg::usp_state_t  state;          // capture sequencer
  logic [3:0]           settle_cnt;     // settle counter
  logic                 hd_sync;        // synchronised half-duplex strap
  logic                 ir_sync;        // synchronised ir strap
  logic                 rx_sync;        // synchronised rx pin
  logic                 sleep_pin_sync; // synchronised sleep pin
  logic                 sleep_req;      // forced sleep armed
  logic                 sleep_mode;     // device asleep

  // every pin passes two flops before logic looks at it
  usp_sync2 u_sync_hd (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .d_in(half_duplex_strap_n_in), .q_out(hd_sync));
  usp_sync2 u_sync_ir (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .d_in(infrared_strap_n_in), .q_out(ir_sync));
  usp_sync2 u_sync_rx (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .d_in(rx_pin_in), .q_out(rx_sync));
  usp_sync2 u_sync_sl (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .d_in(sleep_powerdown_pin_in), .q_out(sleep_pin_sync));

  // strap capture: wait for sync to fill, catch once, then lock forever
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state      <= usp_pkg::USP_ST_SETTLE;
      settle_cnt <= 4'h0;
      straps     <= '{half_duplex_n: usp_pkg::STRAP_RESET_VAL,
                      infrared_n: usp_pkg::STRAP_RESET_VAL, valid: 1'b0};
    end else begin
      case (state)
        usp_pkg::USP_ST_SETTLE: begin
          // synchronisers hold their reset value until flushed
          if (settle_cnt == usp_pkg::STRAP_SETTLE_CYC) begin
            state <= usp_pkg::USP_ST_CAPTURE;
          end else begin
            settle_cnt <= settle_cnt + 4'h1;
          end
        end
        usp_pkg::USP_ST_CAPTURE: begin
          straps.half_duplex_n <= hd_sync;  // [R1]
          straps.infrared_n    <= ir_sync;  // [R4]
          straps.valid         <= 1'b1;
          state                <= usp_pkg::USP_ST_LOCKED;
        end
        usp_pkg::USP_ST_LOCKED: begin
          // nothing changes until the next reset [R11]
          state <= usp_pkg::USP_ST_LOCKED;
        end
        default: begin
          state <= usp_pkg::USP_ST_SETTLE;
        end
      endcase
    end
  end

  // rts pin select: flow control or half-duplex direction (active low)
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rts_n_out <= 1'b1;
    end else if (!straps.half_duplex_n) begin
      rts_n_out <= ~tx_dir_in;  // [R3]
    end else begin
      rts_n_out <= rts_flow_n_in;  // [R2]
    end
  end

  // tx pin: plain or infrared, each with its own idle level
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_out <= usp_pkg::TX_IDLE_UART;  // [R10]
    end else if (!straps.infrared_n) begin
      tx_out <= tx_active_in ? tx_ir_in : usp_pkg::TX_IDLE_IR;  // [R6] [R10]
    end else begin
      tx_out <= tx_active_in ? tx_data_in : usp_pkg::TX_IDLE_UART;  // [R5] [R10]
    end
  end

  // rx steering: the unused decoder sees its idle level
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_plain_out <= usp_pkg::RX_IDLE_UART;
      rx_ir_out    <= usp_pkg::TX_IDLE_IR;
    end else if (!straps.infrared_n) begin
      rx_plain_out <= usp_pkg::RX_IDLE_UART;
      rx_ir_out    <= rx_sync;  // [R6]
    end else begin
      rx_plain_out <= rx_sync;  // [R5]
      rx_ir_out    <= usp_pkg::TX_IDLE_IR;
    end
  end

  // forced sleep: arm on sleep input, enter at next byte boundary
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sleep_req  <= 1'b0;
      sleep_mode <= 1'b0;
    end else begin
      // pin only acts as input while not configured as output [R7]
      // its synchroniser resets to 1, so the pin is ignored until the
      // straps are caught, well after the sync has flushed
      if (straps.valid && !sleep_pin_out_en_in && sleep_pin_sync && !sleep_mode) begin
        sleep_req <= 1'b1;
      end else if (sleep_mode) begin
        sleep_req <= 1'b0;
      end
      if (sleep_req && byte_done_in) begin
        sleep_mode <= 1'b1;  // [R8]
      end else if (sleep_cond_in && !tx_active_in) begin
        sleep_mode <= 1'b1;
      end else if (wake_in) begin
        sleep_mode <= 1'b0;
      end
    end
  end

  // sleep pin direction and drive; oe low means driving
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sleep_powerdown_pin_oe_n_out <= 1'b1;  // [R7]
      sleep_powerdown_pin_out      <= 1'b0;
    end else begin
      sleep_powerdown_pin_oe_n_out <= ~sleep_pin_out_en_in;  // [R9]
      sleep_powerdown_pin_out      <= sleep_mode;  // [R9]
    end
  end

  // status mirrors
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sleep_out            <= 1'b0;
      ir_mode_out          <= 1'b0;
      half_duplex_mode_out <= 1'b0;
    end else begin
      sleep_out            <= sleep_mode;
      ir_mode_out          <= ~straps.infrared_n;
      half_duplex_mode_out <= ~straps.half_duplex_n;
    end
  end

  // assertions
  property p_strap_lock;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      straps.valid |=> $stable(straps.half_duplex_n) && $stable(straps.infrared_n);
  endproperty
  a_strap_lock: assert property (p_strap_lock) else $error("strap changed after capture"); // [R11]

  property p_hd_capture;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      state == usp_pkg::USP_ST_CAPTURE |=> straps.half_duplex_n == $past(hd_sync);
  endproperty
  a_hd_capture: assert property (p_hd_capture) else $error("half-duplex strap not caught"); // [R1]

  property p_ir_capture;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      state == usp_pkg::USP_ST_CAPTURE |=> straps.infrared_n == $past(ir_sync);
  endproperty
  a_ir_capture: assert property (p_ir_capture) else $error("ir strap not caught"); // [R4]

  property p_rts_flow;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      straps.valid && straps.half_duplex_n ##1 straps.half_duplex_n
        |-> rts_n_out == $past(rts_flow_n_in);
  endproperty
  a_rts_flow: assert property (p_rts_flow) else $error("rts not flow control"); // [R2]

  property p_rts_dir;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      straps.valid && !straps.half_duplex_n |=> rts_n_out == !$past(tx_dir_in);
  endproperty
  a_rts_dir: assert property (p_rts_dir) else $error("rts not direction control"); // [R3]

  property p_tx_ir_idle;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      straps.valid && !straps.infrared_n && !tx_active_in |=> tx_out == 1'b0;
  endproperty
  a_tx_ir_idle: assert property (p_tx_ir_idle) else $error("ir tx not idle low"); // [R10]

  property p_tx_plain;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      straps.valid && straps.infrared_n && tx_active_in |=> tx_out == $past(tx_data_in);
  endproperty
  a_tx_plain: assert property (p_tx_plain) else $error("plain tx wrong"); // [R5]

  property p_rx_ir;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      straps.valid && !straps.infrared_n |=> rx_ir_out == $past(rx_sync) && rx_plain_out;
  endproperty
  a_rx_ir: assert property (p_rx_ir) else $error("ir rx not steered"); // [R6]

  sequence s_armed_byte;
    sleep_req && byte_done_in;
  endsequence
  property p_forced_sleep;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      s_armed_byte ##1 1'b1 |-> sleep_mode ##1 sleep_out;
  endproperty
  a_forced_sleep: assert property (p_forced_sleep) else $error("forced sleep missed"); // [R8]

  property p_pin_input;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      !sleep_pin_out_en_in |=> sleep_powerdown_pin_oe_n_out;
  endproperty
  a_pin_input: assert property (p_pin_input) else $error("sleep pin driven as input"); // [R7]

  property p_pin_output;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      sleep_pin_out_en_in |=> !sleep_powerdown_pin_oe_n_out
        && sleep_powerdown_pin_out == $past(sleep_mode);
  endproperty
  a_pin_output: assert property (p_pin_output) else $error("sleep pin not reporting"); // [R9]

  // the sync reset value must never arm a forced sleep
  property p_no_early_arm;
    @(posedge clk_sys_in) disable iff (!rst_n_in)
      !straps.valid |-> !sleep_req;
  endproperty
  a_no_early_arm: assert property (p_no_early_arm) else $error("sleep armed too early"); // [R7]
endmodule

// ===== testbench/usp_host_model.sv
// host side of the sleep pin: drives the request while the pin is an input
module usp_host_model (
  // host intent
  input  wire logic host_sleep_req_in,
  // device drive of the pin
  input  wire logic pin_out_in,
  input  wire logic oe_n_in,
  // resolved wire level
  output logic      pin_level_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // host lets go once the device drives, so no contention is modelled
  assign pin_level_out = oe_n_in ? host_sleep_req_in : pin_out_in;
endmodule

// ===== testbench/tb_uart_strap_and_sleep_pin_control.sv
module tb_uart_strap_and_sleep_pin_control;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {int c; int s; logic e;} usp_note_t;
  logic clk_sys_in, rst_n_in, hd_n, ir_n, rts_f, dir, txd, txi, act, bd, cond, wake, oen, rx;
  logic req, lvl, rts, tx, rxp, rxi, slp, pout, poe, irm, hdm;
  logic [1:0]  md;                 // strap setting of this pass
  logic [2:0]  rxh;                // rx pin history, newest in bit 0
  logic [31:0] seed = 32'h00017625;
  logic [8:0]  outs;
  usp_note_t   q[$];               // expected results, oldest first
  int          cyc, mismatches, n_checks;
  string nm[9] = '{"rts", "tx", "rx_plain", "rx_ir", "sleep", "pin_out", "oe_n", "ir", "hd"};
  assign outs = {hdm, irm, poe, pout, slp, rxi, rxp, tx, rts};

  usp_pin_control u_dut (.clk_sys_in, .rst_n_in, .half_duplex_strap_n_in(hd_n),
    .infrared_strap_n_in(ir_n), .rts_flow_n_in(rts_f), .tx_dir_in(dir), .tx_data_in(txd),
    .tx_ir_in(txi), .tx_active_in(act), .byte_done_in(bd), .sleep_cond_in(cond),
    .wake_in(wake), .sleep_pin_out_en_in(oen), .rts_n_out(rts), .tx_out(tx),
    .rx_pin_in(rx), .rx_plain_out(rxp), .rx_ir_out(rxi), .sleep_powerdown_pin_in(lvl),
    .sleep_powerdown_pin_out(pout), .sleep_powerdown_pin_oe_n_out(poe),
    .sleep_out(slp), .ir_mode_out(irm), .half_duplex_mode_out(hdm));
  usp_host_model u_host (.host_sleep_req_in(req), .pin_out_in(pout), .oe_n_in(poe),
    .pin_level_out(lvl));

  // xorshift source, fixed start so runs repeat
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic note(int c, int s, logic e);
    q.push_back('{c, s, e});
  endtask
  task automatic chk(usp_note_t n);
    n_checks++;
    if (outs[n.s] !== n.e) begin
      mismatches++;
      $display("wrong value %s exp %b got %b", nm[n.s], n.e, outs[n.s]);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // reset with given straps, then let capture finish
  task automatic rst(logic [1:0] s);
    rst_n_in = 1'b0;
    hd_n = s[1];
    ir_n = s[0];
    repeat (20) @(negedge clk_sys_in);
    rst_n_in = 1'b1;
    repeat (10) @(negedge clk_sys_in);
    note(cyc + 1, 7, ~s[0]);
    note(cyc + 1, 8, ~s[1]);
    // flipped straps after capture must change nothing
    hd_n = ~hd_n;
    ir_n = ~ir_n;
    repeat (3) @(negedge clk_sys_in);
    note(cyc + 1, 7, ~s[0]);
    note(cyc + 1, 8, ~s[1]);
  endtask
  // one random cycle of core and line traffic
  task automatic step();
    logic [31:0] r;
    r = xs();
    {rx, txi, txd, act, dir, rts_f} = r[5:0];
    rxh = {rxh[1:0], rx};
    note(cyc + 1, 0, md[1] ? rts_f : ~dir);
    note(cyc + 1, 1, act ? (md[0] ? txd : txi) : md[0]);
    note(cyc + 1, 2, md[0] ? rxh[2] : 1'b1);
    note(cyc + 1, 3, md[0] ? 1'b0 : rxh[2]);
    @(negedge clk_sys_in);
  endtask

  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  // monitor: counts edges, compares due notes once outputs settle
  always @(posedge clk_sys_in) begin
    cyc = cyc + 1;
    if (cyc > 20000) begin
      mismatches++;
      test_done();
    end else begin
      #1;
      while (q.size() > 0 && q[0].c <= cyc) chk(q.pop_front());
    end
  end

  initial begin
    {rts_f, dir, txd, txi, act, bd, cond, wake, oen, req} = '0;
    rst_n_in = 1'b0;
    rx = 1'b1;
    cyc = 0;
    mismatches = 0;
    n_checks = 0;
    for (int s = 0; s < 4; s++) begin
      md = s[1:0];
      rst(md);
      rxh = {3{rx}};
      repeat (40) step();
    end
    // a byte with no sleep request must not put the part to sleep
    act = 1'b0;
    bd = 1'b1;
    @(negedge clk_sys_in);
    bd = 1'b0;
    note(cyc + 1, 4, 1'b0);
    @(negedge clk_sys_in);
    // sleep request armed, entry only on the next byte
    act = 1'b0;
    req = 1'b1;
    repeat (4) @(negedge clk_sys_in);
    note(cyc + 1, 4, 1'b0);
    bd = 1'b1;
    note(cyc + 2, 4, 1'b1);
    note(cyc + 2, 5, 1'b1);
    note(cyc + 2, 6, 1'b1);
    @(negedge clk_sys_in);
    bd = 1'b0;
    req = 1'b0;
    repeat (3) @(negedge clk_sys_in);
    wake = 1'b1;
    @(negedge clk_sys_in);
    wake = 1'b0;
    repeat (3) @(negedge clk_sys_in);
    note(cyc + 1, 4, 1'b0);
    // pin turned to output, normal entry shows on it
    oen = 1'b1;
    cond = 1'b1;
    repeat (4) @(negedge clk_sys_in);
    note(cyc + 1, 6, 1'b0);
    note(cyc + 1, 5, 1'b1);
    repeat (3) @(negedge clk_sys_in);
    test_done();
  end
endmodule
